// file: rtl/expander_pkg.sv
// shared constants and types of the i2c port expander
package expander_pkg;
   localparam logic [7:0] GC_WRITE_BYTE = 8'h00;
   localparam logic [7:0] RESET_CMD     = 8'h06;
   localparam logic [6:0] ID_ADDR       = 7'h7c;
   localparam logic [7:0] PORT_RESET    = 8'hff;
   localparam logic [3:0] BYTE_BITS     = 4'h8;
   localparam logic [2:0] LAST_BIT      = 3'h7;
   localparam logic [1:0] ID_LAST_BYTE  = 2'h2;
   localparam int         ID_BITS       = 24;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_GC_DATA,
      ST_ID_SEL,
      ST_WR_DATA,
      ST_RD_DATA,
      ST_ACK,
      ST_MACK,
      ST_IGNORE
   } state_t;
endpackage

// file: rtl/port_ctl_if.sv
// carrier between the bus engine and the port line stage
interface port_ctl_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] latch;
   logic             strongHigh;
   logic [WIDTH-1:0] level;

   modport ctl   (output latch, output strongHigh, input level);
   modport stage (input latch, input strongHigh, output level);
endinterface

// file: rtl/port_stage.sv
// quasi-bidirectional port line drivers and input sampling
module port_stage #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   port_ctl_if.stage             ctl,
   input  wire logic [WIDTH-1:0] portIn,
   output logic      [WIDTH-1:0] portOut,
   output logic      [WIDTH-1:0] portOe_b
);
   initial begin
      if (WIDTH < 1) begin
         $error("port_stage: WIDTH must be at least 1");
      end
   end

   logic [WIDTH-1:0] next_portOut;
   logic [WIDTH-1:0] next_portOe_b;
   logic [WIDTH-1:0] level;
   logic [WIDTH-1:0] next_level;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_line
         always_comb begin
            next_level[i] = portIn[i];
            if (!ctl.latch[i]) begin
               // strong sink held until the bit is rewritten
               next_portOut[i]  = 1'b0;
               next_portOe_b[i] = 1'b0;
            end else if (ctl.strongHigh) begin
               // accelerator only during ack clock high, avoids long contention
               next_portOut[i]  = 1'b1;
               next_portOe_b[i] = 1'b0;
            end else begin
               // weak source only, pin usable as input
               next_portOut[i]  = 1'b1;
               next_portOe_b[i] = 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         portOut  <= '1;
         portOe_b <= '1;
         level    <= '1;
      end else begin
         portOut  <= next_portOut;
         portOe_b <= next_portOe_b;
         level    <= next_level;
      end
   end

   assign ctl.level = level;
endmodule

// file: rtl/i2c_port_expander.sv
// i2c slave engine of the 8-bit quasi-bidirectional port expander
// Summary of operation
// - acknowledge general call only when the whole address byte is zero
// - general call address with read bit set gets no acknowledge
// - after general call only data byte 06h is acknowledged
// - further bytes after the reset byte are never acknowledged
// - acknowledged reset byte then stop restores every power-up default
// - repeated start after the reset byte cancels the software reset
// - hardwired 24-bit identity: 12 maker, 9 part, 3 revision bits
// - identity read opens with start and reserved address 1111100 write
// - next byte acknowledged only if upper seven bits match own address
// - repeated start, reserved address read, then identity bytes are sent
// - stop then start, or access to another slave, cancels identity read
// - identity sent most significant bit first, maker, part, revision
// - master nack on an identity byte ends the read and idles
// - continued acks after third identity byte wrap to first byte
// - single port register, reads return actual pin levels
// - after reset all port bits high on weak source only
// - one data byte writes or reads all eight lines, bits independent
// - written one gets strong pull-up only during ack clock high
// - written zero turns strong sink on until bit is rewritten
// - port data follows address byte directly, no command byte
// - any number of write bytes, each acknowledged byte replaces port
// - read sends port byte; master acks to reread or nacks then stops
// - reset pin low holds registers and bus engine at defaults
module i2c_port_expander #(
   parameter int         WIDTH    = 8,
   parameter logic [11:0] MAKER_ID = 12'h5a5, // arbitrary value
   parameter logic [8:0]  PART_ID  = 9'h0c3,  // arbitrary value
   parameter logic [2:0]  DIE_REV  = 3'h1     // arbitrary value
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             sclIn,
   input  wire logic             sdaIn,
   output logic                  sdaOut,
   output logic                  sdaOe_b,
   input  wire logic [6:0]       ownAddress,
   input  wire logic [WIDTH-1:0] portIn,
   output logic      [WIDTH-1:0] portOut,
   output logic      [WIDTH-1:0] portOe_b
);
   initial begin
      if (WIDTH != 8) begin
         $error("i2c_port_expander: the port is one byte wide");
      end
      if ($bits(MAKER_ID) + $bits(PART_ID) + $bits(DIE_REV) != expander_pkg::ID_BITS) begin
         $error("i2c_port_expander: identity fields must fill the identity word");
      end
   end

   localparam int ID_BITS_W = expander_pkg::ID_BITS;
   // identity bits are constants, so they cost no flip-flops
   localparam logic [ID_BITS_W-1:0] ID_WORD = {MAKER_ID, PART_ID, DIE_REV};

   port_ctl_if #(.WIDTH(WIDTH)) portCtl ();

   port_stage #(.WIDTH(WIDTH)) u_stage (
      .clk      (clk),
      .rst_b    (rst_b),
      .ctl      (portCtl),
      .portIn   (portIn),
      .portOut  (portOut),
      .portOe_b (portOe_b)
   );

   // scl and sda taken as synchronous; no glitch filter on either line
   // line history for edge and condition detection
   logic sclQ;
   logic sdaQ;
   logic next_sclQ;
   logic next_sdaQ;

   always_comb begin
      next_sclQ = sclIn;
      next_sdaQ = sdaIn;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sclQ <= 1'b1;
         sdaQ <= 1'b1;
      end else begin
         sclQ <= next_sclQ;
         sdaQ <= next_sdaQ;
      end
   end

   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;

   assign sclRise   = sclIn & ~sclQ;
   assign sclFall   = ~sclIn & sclQ;
   assign startCond = sclIn & sclQ & sdaQ & ~sdaIn;
   assign stopCond  = sclIn & sclQ & ~sdaQ & sdaIn;

   // bus engine state
   expander_pkg::state_t state;
   expander_pkg::state_t next_state;
   expander_pkg::state_t afterState;
   expander_pkg::state_t next_afterState;
   logic [3:0]       bitCnt;
   logic [3:0]       next_bitCnt;
   logic [7:0]       shiftReg;
   logic [7:0]       next_shiftReg;
   logic             sdaHold_b;
   logic             next_sdaHold_b;
   logic             resetArmed;
   logic             next_resetArmed;
   logic             idArmed;
   logic             next_idArmed;
   logic             idRead;
   logic             next_idRead;
   logic [1:0]       idIndex;
   logic [1:0]       next_idIndex;
   logic [WIDTH-1:0] portLatch;
   logic [WIDTH-1:0] next_portLatch;
   logic [WIDTH-1:0] pendingPort;
   logic [WIDTH-1:0] next_pendingPort;
   logic             portWrite;
   logic             next_portWrite;
   logic             strongHigh;
   logic             next_strongHigh;
   logic             masterAck;
   logic             next_masterAck;
   logic [7:0]       txByte;

   // identity bytes leave msb first; otherwise live pin levels
   always_comb begin
      txByte = portCtl.level;
      if (idRead) begin
         case (idIndex)
            2'h0:    txByte = ID_WORD[23:16];
            2'h1:    txByte = ID_WORD[15:8];
            default: txByte = ID_WORD[7:0];
         endcase
      end
   end

   always_comb begin
      next_state       = state;
      next_afterState  = afterState;
      next_bitCnt      = bitCnt;
      next_shiftReg    = shiftReg;
      next_sdaHold_b   = sdaHold_b;
      next_resetArmed  = resetArmed;
      next_idArmed     = idArmed;
      next_idRead      = idRead;
      next_idIndex     = idIndex;
      next_portLatch   = portLatch;
      next_pendingPort = pendingPort;
      next_portWrite   = portWrite;
      next_strongHigh  = strongHigh;
      next_masterAck   = masterAck;
      if (stopCond) begin
         next_state      = expander_pkg::ST_IDLE;
         next_sdaHold_b  = 1'b1;
         next_idArmed    = 1'b0;
         next_strongHigh = 1'b0;
         next_portWrite  = 1'b0;
         next_resetArmed = 1'b0;
         if (resetArmed) begin
            // software reset only on stop after an acked 06h
            next_portLatch = expander_pkg::PORT_RESET;
            next_idRead    = 1'b0;
            next_idIndex   = 2'h0;
         end
      end else if (startCond) begin
         // repeated start keeps a pending identity selection alive
         next_state      = expander_pkg::ST_ADDR;
         next_bitCnt     = 4'h0;
         next_sdaHold_b  = 1'b1;
         next_resetArmed = 1'b0;
         next_strongHigh = 1'b0;
         next_portWrite  = 1'b0;
      end else begin
         case (state)
            expander_pkg::ST_ADDR, expander_pkg::ST_GC_DATA,
            expander_pkg::ST_ID_SEL, expander_pkg::ST_WR_DATA: begin
               if (sclRise) begin
                  next_shiftReg = {shiftReg[6:0], sdaIn};
                  next_bitCnt   = bitCnt + 4'h1;
               end else if (sclFall && bitCnt == expander_pkg::BYTE_BITS) begin
                  next_bitCnt = 4'h0;
                  next_state  = expander_pkg::ST_IGNORE;
                  case (state)
                     expander_pkg::ST_ADDR: begin
                        next_idArmed = 1'b0;
                        if (shiftReg == expander_pkg::GC_WRITE_BYTE) begin
                           next_state      = expander_pkg::ST_ACK;
                           next_afterState = expander_pkg::ST_GC_DATA;
                        end else if (shiftReg[7:1] == expander_pkg::GC_WRITE_BYTE[7:1]) begin
                           // general call read is never answered
                           next_state = expander_pkg::ST_IGNORE;
                        end else if (shiftReg[7:1] == expander_pkg::ID_ADDR) begin
                           if (!shiftReg[0]) begin
                              next_state      = expander_pkg::ST_ACK;
                              next_afterState = expander_pkg::ST_ID_SEL;
                           end else if (idArmed) begin
                              next_state      = expander_pkg::ST_ACK;
                              next_afterState = expander_pkg::ST_RD_DATA;
                              next_idRead     = 1'b1;
                              next_idIndex    = 2'h0;
                           end
                        end else if (shiftReg[7:1] == ownAddress) begin
                           next_state      = expander_pkg::ST_ACK;
                           next_idRead     = 1'b0;
                           next_afterState = shiftReg[0] ? expander_pkg::ST_RD_DATA : expander_pkg::ST_WR_DATA;
                        end
                        // any other address is left unacked
                     end
                     expander_pkg::ST_GC_DATA: begin
                        // every device acks 06h; the reset itself waits for the stop
                        if (shiftReg == expander_pkg::RESET_CMD) begin
                           next_state      = expander_pkg::ST_ACK;
                           next_afterState = expander_pkg::ST_IGNORE;
                           next_resetArmed = 1'b1;
                        end
                     end
                     expander_pkg::ST_ID_SEL: begin
                        // lsb of the selecting byte is a don't care
                        if (shiftReg[7:1] == ownAddress) begin
                           next_state      = expander_pkg::ST_ACK;
                           next_afterState = expander_pkg::ST_IGNORE;
                           next_idArmed    = 1'b1;
                        end
                     end
                     default: begin
                        next_state       = expander_pkg::ST_ACK;
                        next_afterState  = expander_pkg::ST_WR_DATA;
                        next_pendingPort = shiftReg;
                        next_portWrite   = 1'b1;
                     end
                  endcase
                  if (next_state == expander_pkg::ST_ACK) begin
                     next_sdaHold_b = 1'b0;
                  end
               end
            end
            expander_pkg::ST_ACK: begin
               if (sclRise && portWrite) begin
                  // port changes as the ack clock goes high
                  // a stretched ack clock stretches the strong pull-up with it
                  next_portLatch  = pendingPort;
                  next_strongHigh = 1'b1;
               end else if (sclFall) begin
                  next_strongHigh = 1'b0;
                  next_portWrite  = 1'b0;
                  next_sdaHold_b  = 1'b1;
                  next_state      = afterState;
                  if (afterState == expander_pkg::ST_RD_DATA) begin
                     next_shiftReg  = txByte;
                     next_sdaHold_b = txByte[7];
                     next_bitCnt    = 4'h0;
                  end
               end
            end
            expander_pkg::ST_RD_DATA: begin
               if (sclFall) begin
                  if (bitCnt[2:0] == expander_pkg::LAST_BIT) begin
                     next_sdaHold_b = 1'b1;
                     next_state     = expander_pkg::ST_MACK;
                     next_masterAck = 1'b0;
                  end else begin
                     next_shiftReg  = {shiftReg[6:0], 1'b0};
                     next_sdaHold_b = shiftReg[6];
                     next_bitCnt    = bitCnt + 4'h1;
                  end
               end
            end
            expander_pkg::ST_MACK: begin
               if (sclRise) begin
                  next_masterAck = ~sdaIn;
                  if (sdaIn) begin
                     next_state  = expander_pkg::ST_IGNORE;
                     next_idRead = 1'b0;
                  end else if (idRead) begin
                     next_idIndex = (idIndex == expander_pkg::ID_LAST_BYTE) ? 2'h0 : idIndex + 2'h1;
                  end
               end else if (sclFall && masterAck) begin
                  // pins sampled afresh for every byte read
                  next_shiftReg  = txByte;
                  next_sdaHold_b = txByte[7];
                  next_bitCnt    = 4'h0;
                  next_state     = expander_pkg::ST_RD_DATA;
               end
            end
            expander_pkg::ST_IDLE, expander_pkg::ST_IGNORE: begin
               next_sdaHold_b = 1'b1;
            end
            default: begin
               next_state = expander_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // reset pin holds everything at power-up values
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state       <= expander_pkg::ST_IDLE;
         afterState  <= expander_pkg::ST_IDLE;
         bitCnt      <= 4'h0;
         shiftReg    <= 8'h00;
         sdaHold_b   <= 1'b1;
         resetArmed  <= 1'b0;
         idArmed     <= 1'b0;
         idRead      <= 1'b0;
         idIndex     <= 2'h0;
         portLatch   <= expander_pkg::PORT_RESET;
         pendingPort <= expander_pkg::PORT_RESET;
         portWrite   <= 1'b0;
         strongHigh  <= 1'b0;
         masterAck   <= 1'b0;
      end else begin
         state       <= next_state;
         afterState  <= next_afterState;
         bitCnt      <= next_bitCnt;
         shiftReg    <= next_shiftReg;
         sdaHold_b   <= next_sdaHold_b;
         resetArmed  <= next_resetArmed;
         idArmed     <= next_idArmed;
         idRead      <= next_idRead;
         idIndex     <= next_idIndex;
         portLatch   <= next_portLatch;
         pendingPort <= next_pendingPort;
         portWrite   <= next_portWrite;
         strongHigh  <= next_strongHigh;
         masterAck   <= next_masterAck;
      end
   end

   assign portCtl.latch      = portLatch;
   assign portCtl.strongHigh = strongHigh;
   // open drain: only ever pulls low
   assign sdaOut  = 1'b0;
   assign sdaOe_b = sdaHold_b;
endmodule

// file: verif/i2c_port_expander_assertions.sv
// pin level checks on the i2c port expander
module i2c_port_expander_assertions #(
   parameter int WIDTH = 8
) (
   input wire logic             clk,
   input wire logic             rst_b,
   input wire logic             sclIn,
   input wire logic             sdaIn,
   input wire logic             sdaOut,
   input wire logic             sdaOe_b,
   input wire logic [6:0]       ownAddress,
   input wire logic [WIDTH-1:0] portIn,
   input wire logic [WIDTH-1:0] portOut,
   input wire logic [WIDTH-1:0] portOe_b
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [WIDTH-1:0] strongHi;
   logic [WIDTH-1:0] sink;

   assign strongHi = ~portOe_b & portOut;
   assign sink     = ~portOe_b & ~portOut;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   chk_reset_defaults: assert property ($rose(rst_b) |-> &portOe_b && &portOut && sdaOe_b)
      else $error("port or sda not at default after reset");
   chk_pullup_window: assert property (|strongHi |-> $past(sclIn, 2))
      else $error("strong pull-up outside ack clock high");
   chk_pullup_ends: assert property ($fell(sclIn) |-> ##2 strongHi == '0)
      else $error("strong pull-up kept after clock fall");
   chk_sink_hold: assert property (sink != $past(sink) |-> $past(sclIn, 2))
      else $error("sink changed outside a write");
   chk_low_driven: assert property ((~portOut & portOe_b) == '0)
      else $error("low port bit without strong sink");
   chk_port_timing: assert property ($changed(portOe_b) |-> $past(sclIn, 2) || $past(sclIn, 3))
      else $error("port drive changed away from ack clock");
   chk_sda_timing: assert property ($changed(sdaOe_b) |-> $past(sclIn, 2) && !$past(sclIn))
      else $error("sda drive changed outside clock low");
   chk_sda_pulls_low: assert property (!sdaOe_b |-> !sdaOut)
      else $error("sda driven high");

   cov_pullup: cover property (|strongHi);
   cov_ack: cover property ($fell(sdaOe_b));
   cov_port_restore: cover property ($changed(portOe_b) && &portOe_b);
endmodule

bind i2c_port_expander i2c_port_expander_assertions #(.WIDTH(WIDTH)) assertCheck (
   .clk, .rst_b, .sclIn, .sdaIn, .sdaOut, .sdaOe_b, .ownAddress, .portIn, .portOut, .portOe_b);

// file: verif/i2c_master_model.sv
// i2c bus master model driving the expander's bus lines
module i2c_master_model (
   input  wire logic clk,
   input  wire logic sdaLine,
   output logic      scl,
   output logic      sdaDrv
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // sda moves only while scl is low, so no false start or stop
   task automatic bit_io(input logic b, output logic seen);
      sdaDrv = b;
      wait_clk(3);
      scl = 1'b1;
      wait_clk(2);
      seen = sdaLine;
      wait_clk(2);
      scl = 1'b0;
      wait_clk(2);
   endtask

   task automatic start();
      sdaDrv = 1'b1;
      wait_clk(2);
      scl = 1'b1;
      wait_clk(3);
      sdaDrv = 1'b0;
      wait_clk(3);
      scl = 1'b0;
      wait_clk(2);
   endtask

   task automatic stop();
      sdaDrv = 1'b0;
      wait_clk(2);
      scl = 1'b1;
      wait_clk(3);
      sdaDrv = 1'b1;
      wait_clk(6);
   endtask

   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], seen);
      end
      bit_io(1'b1, seen);
      ack = ~seen;
   endtask

   // nack on the last byte hands the line back for the stop
   task automatic get_byte(input logic more, output logic [7:0] d);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, seen);
         d[i] = seen;
      end
      bit_io(~more, seen);
   endtask
endmodule

// file: verif/i2c_expander_reset_id_port_test.sv
// self-checking bench for the i2c port expander
module i2c_expander_reset_id_port_test;
   timeunit 1ns;
   timeprecision 100ps;

   localparam logic [6:0]  OWN_ADDR = 7'h2a;
   localparam logic [11:0] MAKER    = 12'h3b7; // arbitrary value
   localparam logic [8:0]  PART     = 9'h14e;  // arbitrary value
   localparam logic [2:0]  REV      = 3'h5;    // arbitrary value
   localparam logic [23:0] ID_WORD  = {MAKER, PART, REV};

   logic       clk;
   logic       rst_b;
   logic       scl;
   logic       sdaDrv;
   logic       sdaLine;
   logic       sdaOut;
   logic       sdaOe_b;
   logic [7:0] portIn;
   logic [7:0] portOut;
   logic [7:0] portOe_b;
   logic [7:0] extLow;
   logic       ack;
   logic [7:0] data;
   int         mismatches;
   int         checked;

   // open drain bus with pull-up; weak port bits follow the external load
   assign sdaLine = sdaDrv & (sdaOe_b | sdaOut);
   assign portIn  = (~portOe_b & portOut) | (portOe_b & ~extLow);

   always #4 clk = ~clk;

   i2c_port_expander #(.MAKER_ID(MAKER), .PART_ID(PART), .DIE_REV(REV)) DUT (
      .clk        (clk),
      .rst_b      (rst_b),
      .sclIn      (scl),
      .sdaIn      (sdaLine),
      .sdaOut     (sdaOut),
      .sdaOe_b    (sdaOe_b),
      .ownAddress (OWN_ADDR),
      .portIn     (portIn),
      .portOut    (portOut),
      .portOe_b   (portOe_b)
   );

   i2c_master_model master (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaDrv(sdaDrv));

   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic send(input logic [7:0] d, input logic expAck);
      master.send_byte(d, ack);
      check("ack", {23'h0, expAck}, {23'h0, ack});
   endtask

   task automatic recv(input logic more, input logic [7:0] exp);
      master.get_byte(more, data);
      check("read byte", {16'h0, exp}, {16'h0, data});
   endtask

   task automatic ports(input logic [7:0] expOe);
      check("port enables", {16'h0, expOe}, {16'h0, portOe_b});
      check("sink bits", 24'h0, {16'h0, portOut & ~expOe});
   endtask

   task automatic write_port(input logic [7:0] d);
      master.start();
      send({OWN_ADDR, 1'b0}, 1'b1);
      send(d, 1'b1);
      master.stop();
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      summarize();
   end

   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      extLow = 8'h00;
      repeat (4) @(posedge clk);
      #1;
      rst_b = 1'b1;
      master.wait_clk(2);
      ports(8'hff);
      check("sda idle", 24'h1, {23'h0, sdaOe_b});
      master.start();
      send({OWN_ADDR, 1'b0}, 1'b1);
      send(8'h5a, 1'b1);
      send(8'hc3, 1'b1);
      master.stop();
      ports(8'hc3);
      extLow = 8'h81;
      master.start();
      send({OWN_ADDR, 1'b1}, 1'b1);
      recv(1'b1, 8'h42);
      recv(1'b0, 8'h42);
      master.stop();
      master.start();
      send({OWN_ADDR, 1'b0}, 1'b1);
      send(8'hff, 1'b1);
      master.start();
      send({OWN_ADDR, 1'b1}, 1'b1);
      recv(1'b0, 8'h7e);
      master.stop();
      write_port(8'h0f);
      master.start();
      send(8'h01, 1'b0);
      master.stop();
      master.start();
      send(8'h00, 1'b1);
      send(8'h07, 1'b0);
      master.stop();
      ports(8'h0f);
      master.start();
      send(8'h00, 1'b1);
      send(8'h06, 1'b1);
      send(8'h06, 1'b0);
      master.start();
      send({OWN_ADDR, 1'b1}, 1'b1);
      recv(1'b0, 8'h0e);
      master.stop();
      ports(8'h0f);
      master.start();
      send(8'h00, 1'b1);
      send(8'h06, 1'b1);
      master.stop();
      ports(8'hff);
      write_port(8'h33);
      ports(8'h33);
      master.start();
      send(8'hf8, 1'b1);
      send({OWN_ADDR, 1'b1}, 1'b1);
      master.start();
      send(8'hf9, 1'b1);
      for (int k = 0; k < 4; k++) begin
         recv(k < 3, ID_WORD[23 - 8 * (k % 3) -: 8]);
      end
      master.stop();
      master.start();
      send(8'hf8, 1'b1);
      send({OWN_ADDR ^ 7'h01, 1'b0}, 1'b0);
      master.stop();
      master.start();
      send(8'hf8, 1'b1);
      send({OWN_ADDR, 1'b0}, 1'b1);
      master.stop();
      master.start();
      send(8'hf9, 1'b0);
      master.stop();
      write_port(8'h00);
      ports(8'h00);
      rst_b = 1'b0;
      master.wait_clk(2);
      ports(8'hff);
      rst_b = 1'b1;
      master.wait_clk(2);
      ports(8'hff);
      summarize();
   end
endmodule
